//--- dced_dispatcher.sv
`timescale 1ns/1ns
`default_nettype none
module dced_dispatcher #(
   parameter int unsigned TICK_CYCLES = dced_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        rst_n,
   // register port
   input  wire logic [dced_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [dced_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [dced_pkg::DATA_W-1:0] reg_rdata,
   // controller request pins
   input  wire logic                        ctl_req,
   input  wire logic [dced_pkg::CMD_W-1:0]  ctl_cmd,
   input  wire logic [dced_pkg::OPND_W-1:0] ctl_operand,
   // controller answer
   output logic                             ctl_done,
   output logic                             ctl_ok,
   output logic                             ctl_reject,
   output logic      [7:0]                  ctl_data,
   // servo processor link
   output logic                             srv_cmd_valid,
   output logic      [dced_pkg::CMD_W-1:0]  srv_cmd,
   output logic      [dced_pkg::OPND_W-1:0] srv_operand,
   output logic                             srv_abort,
   input  wire logic                        srv_stat_strobe,
   input  wire logic                        srv_stat_ok,
   // drive condition pins
   input  wire logic                        unit_ready,
   input  wire logic                        motor_at_speed,
   input  wire logic                        pwr_write_bad,
   input  wire logic                        pwr_servo_bad,
   // housekeeping slice pulses and inhibits
   output logic      [dced_pkg::SLICE_COUNT-1:0] hk_slice_go,
   output logic                             write_inhibit,
   output logic                             servo_inhibit
);

   localparam int SYNC_W = 18;          // width of synchronised pin bundle
   localparam int CNT_W  = 24;          // tick counter width
   localparam int SL_N   = dced_pkg::SLICE_COUNT;
   if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << CNT_W)) begin : g_tick_range  // divider must fit
      $error("TICK_CYCLES out of range for the timer divider");
   end

   // pin synchroniser, two stages, plus one delay for edges
   logic [SYNC_W-1:0] pin_raw;          // bundled pins
   logic [SYNC_W-1:0] meta_r;           // first stage, read only by sync_r
   logic [SYNC_W-1:0] sync_r;           // second stage
   logic              req_d_r;          // delayed request for edge
   logic              sst_d_r;          // delayed servo strobe for edge
   assign pin_raw = {ctl_req, ctl_cmd, ctl_operand, srv_stat_strobe, srv_stat_ok,
                     unit_ready, motor_at_speed, pwr_write_bad, pwr_servo_bad};

   // synchroniser flops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r  <= '0;
         sync_r  <= '0;
         req_d_r <= 1'b0;
         sst_d_r <= 1'b0;
      end else begin
         meta_r  <= pin_raw;
         sync_r  <= meta_r;
         req_d_r <= sync_r[17];
         sst_d_r <= sync_r[5];
      end
   end

   // decoded synchronised pins
   wire                         req_s      = sync_r[17];
   wire [dced_pkg::CMD_W-1:0]   cmd_s      = sync_r[16:14];
   wire [dced_pkg::OPND_W-1:0]  opnd_s     = sync_r[13:6];
   wire                         sst_s      = sync_r[5];
   wire                         sok_s      = sync_r[4];
   wire                         ready_s    = sync_r[3];
   wire                         speed_s    = sync_r[2];
   wire                         wbad_s     = sync_r[1];
   wire                         sbad_s     = sync_r[0];
   wire                         io_evt     = req_s && !req_d_r;
   wire                         srv_evt    = sst_s && !sst_d_r;

   // state and registers
   dced_pkg::dced_state_t state_r, state_nxt;
   logic              en_r;             // event sources enabled
   logic [7:0]        timeout_r;        // servo timeout in ticks
   logic [CNT_W-1:0]  tick_cnt_r;       // timer divider
   logic              tick_evt;         // timer event this cycle
   logic [2:0]        slice_r;          // next slice to run
   logic              srv_pend_r;       // servo event pending
   logic              tick_pend_r;      // timer event pending
   logic              io_pend_r;        // controller request pending
   logic              to_pend_r;        // timeout pending
   logic              busy_r;           // servo operation outstanding
   logic [7:0]        to_cnt_r;         // ticks spent on servo operation
   logic              sok_r;            // captured servo verdict
   logic [2:0]        qcmd_r;           // queued request code
   logic [7:0]        qopnd_r;          // queued operand
   logic              last_ok_r;        // last servo result good
   logic              last_to_r;        // last servo result timed out
   logic [31:0]       rdata_nxt;        // read mux

   // register decode
   wire wr_ctrl    = reg_wr && (reg_addr == dced_pkg::REG_CTRL);
   wire wr_timeout = reg_wr && (reg_addr == dced_pkg::REG_TIMEOUT);
   wire to_hit     = busy_r && tick_evt && ((to_cnt_r + 8'h01) >= timeout_r);
   wire accept     = dced_pkg::cmd_allowed(qcmd_r, ready_s, speed_s, servo_inhibit);
   wire go_servo   = accept && dced_pkg::needs_servo(qcmd_r);
   wire [7:0] op_status = {4'h0, servo_inhibit, write_inhibit, speed_s, ready_s};
   wire [7:0] dg_status = {last_to_r, last_ok_r, busy_r, 2'h0, qcmd_r};

   // timer divider
   assign tick_evt = en_r && (tick_cnt_r == CNT_W'(TICK_CYCLES - 1));
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)       tick_cnt_r <= '0;
      else if (tick_evt) tick_cnt_r <= '0;
      else if (en_r)    tick_cnt_r <= tick_cnt_r + 1'b1;
   end

   // software registers, init completion enables sources
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_r      <= 1'b0;
         timeout_r <= dced_pkg::TIMEOUT_RST;
      end else begin
         if (wr_ctrl && reg_wdata[dced_pkg::CTRL_INIT_BIT]) en_r <= 1'b1;
         if (wr_timeout) timeout_r <= reg_wdata[7:0];
      end
   end

   // pending flags, a new event wins over its clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         srv_pend_r  <= 1'b0;
         tick_pend_r <= 1'b0;
         io_pend_r   <= 1'b0;
         to_pend_r   <= 1'b0;
         sok_r       <= 1'b0;
         qcmd_r      <= '0;
         qopnd_r     <= '0;
      end else begin
         if (en_r && srv_evt) srv_pend_r <= 1'b1;
         else if (state_r == dced_pkg::ST_SERVO) srv_pend_r <= 1'b0;
         if (srv_evt) sok_r <= sok_s;
         if (tick_evt) tick_pend_r <= 1'b1;
         else if (state_r == dced_pkg::ST_TICK) tick_pend_r <= 1'b0;
         if (en_r && io_evt) io_pend_r <= 1'b1;
         else if (state_r == dced_pkg::ST_IO) io_pend_r <= 1'b0;
         if (to_hit) to_pend_r <= 1'b1;
         else if (state_r == dced_pkg::ST_ABORT) to_pend_r <= 1'b0;
         if (io_evt && (!io_pend_r || state_r == dced_pkg::ST_IO)) begin
            qcmd_r  <= cmd_s;
            qopnd_r <= opnd_s;
         end
      end
   end

   // arbitration and next state
   always_comb begin
      state_nxt = dced_pkg::ST_IDLE;
      unique case (state_r)
         dced_pkg::ST_IDLE: begin
            if (srv_pend_r)                  state_nxt = dced_pkg::ST_SERVO;
            else if (to_pend_r)              state_nxt = dced_pkg::ST_ABORT;
            else if (tick_pend_r)            state_nxt = dced_pkg::ST_TICK;
            else if (io_pend_r && !busy_r)   state_nxt = dced_pkg::ST_IO;
         end
         dced_pkg::ST_TICK, dced_pkg::ST_IO,
         dced_pkg::ST_SERVO, dced_pkg::ST_ABORT: state_nxt = dced_pkg::ST_IDLE;
         default: state_nxt = dced_pkg::ST_IDLE;           // illegal code recovery
      endcase
   end

   // state register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) state_r <= dced_pkg::ST_IDLE;
      else        state_r <= state_nxt;
   end

   // housekeeping slice rotation
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         slice_r     <= '0;
         hk_slice_go <= '0;
      end else if (state_r == dced_pkg::ST_TICK) begin
         // slice 0 panel, 1 speed, 2 power, 3 servo, 4 diag, 5 display
         hk_slice_go <= SL_N'(1) << slice_r;
         slice_r     <= (slice_r == 3'(SL_N - 1)) ? 3'h0 : slice_r + 3'h1;
      end else begin
         hk_slice_go <= '0;
      end
   end

   // servo link and operation timer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r        <= 1'b0;
         to_cnt_r      <= '0;
         srv_cmd_valid <= 1'b0;
         srv_cmd       <= '0;
         srv_operand   <= '0;
         srv_abort     <= 1'b0;
      end else begin
         srv_cmd_valid <= 1'b0;
         srv_abort     <= 1'b0;
         if (state_r == dced_pkg::ST_IO && go_servo) begin
            srv_cmd_valid <= 1'b1;
            srv_cmd       <= qcmd_r;
            srv_operand   <= qopnd_r;
            busy_r        <= 1'b1;
            to_cnt_r      <= '0;
         end else if (state_r == dced_pkg::ST_SERVO) begin
            busy_r <= 1'b0;
         end else if (state_r == dced_pkg::ST_ABORT && busy_r) begin
            srv_abort <= 1'b1;
            busy_r    <= 1'b0;
         end else if (busy_r && tick_evt) begin
            to_cnt_r <= to_cnt_r + 8'h01;
         end
      end
   end

   // controller answers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_done   <= 1'b0;
         ctl_ok     <= 1'b0;
         ctl_reject <= 1'b0;
         ctl_data   <= '0;
         last_ok_r  <= 1'b0;
         last_to_r  <= 1'b0;
      end else begin
         ctl_done   <= 1'b0;
         ctl_reject <= 1'b0;
         if (state_r == dced_pkg::ST_IO) begin
            if (!accept) begin
               ctl_done   <= 1'b1;
               ctl_ok     <= 1'b0;
               ctl_reject <= 1'b1;
            end else if (qcmd_r == dced_pkg::CMD_OP_STAT) begin
               ctl_done <= 1'b1;
               ctl_ok   <= 1'b1;
               ctl_data <= op_status;
            end else if (qcmd_r == dced_pkg::CMD_DIAG_STAT) begin
               ctl_done <= 1'b1;
               ctl_ok   <= 1'b1;
               ctl_data <= dg_status;
            end
         end else if (state_r == dced_pkg::ST_SERVO && busy_r) begin
            ctl_done  <= 1'b1;
            ctl_ok    <= sok_r;
            last_ok_r <= sok_r;
            last_to_r <= 1'b0;
         end else if (state_r == dced_pkg::ST_ABORT && busy_r) begin
            ctl_done  <= 1'b1;
            ctl_ok    <= 1'b0;
            last_ok_r <= 1'b0;
            last_to_r <= 1'b1;
         end
      end
   end

   // supply monitor inhibits
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         write_inhibit <= 1'b1;
         servo_inhibit <= 1'b1;
      end else begin
         write_inhibit <= wbad_s;
         servo_inhibit <= sbad_s;
      end
   end

   // register read, data only in the cycle after the strobe
   always_comb begin
      rdata_nxt = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            dced_pkg::REG_CTRL:    rdata_nxt = {31'h0, en_r};
            dced_pkg::REG_TIMEOUT: rdata_nxt = {24'h0, timeout_r};
            dced_pkg::REG_STATUS:  rdata_nxt = {16'h0, 1'b0, slice_r, to_pend_r, io_pend_r,
                                                tick_pend_r, srv_pend_r, busy_r,
                                                servo_inhibit, write_inhibit, 2'h0, state_r};
            dced_pkg::REG_RESULT:  rdata_nxt = {16'h0, last_to_r, last_ok_r, 3'h0, qcmd_r,
                                                to_cnt_r};
            default:               rdata_nxt = '0;
         endcase
      end
   end

   // read data flop
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) reg_rdata <= '0;
      else        reg_rdata <= rdata_nxt;
   end

   // helper: cycles since last timer event
   logic [CNT_W-1:0] gap_r;
   logic             gap_seen_r;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_r      <= '0;
         gap_seen_r <= 1'b0;
      end else if (tick_evt) begin
         gap_r      <= '0;
         gap_seen_r <= 1'b1;
      end else begin
         gap_r <= gap_r + 1'b1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   AST_TICK_PERIOD: assert property (tick_evt && gap_seen_r |-> gap_r == CNT_W'(TICK_CYCLES - 1))
      else $error("timer event spacing wrong");
   AST_SLICE_ONEHOT: assert property (state_r == dced_pkg::ST_TICK |=>
      hk_slice_go == (SL_N'(1) << $past(slice_r)) && slice_r != $past(slice_r))
      else $error("slice not run in rotation");
   AST_SLICE_ONLY_TICK: assert property ($past(state_r) != dced_pkg::ST_TICK |-> hk_slice_go == '0)
      else $error("slice pulse without timer event");
   AST_DISABLED_IDLE: assert property (!en_r |-> state_r == dced_pkg::ST_IDLE && !tick_pend_r)
      else $error("activity before initialisation");
   AST_PRIO_SERVO: assert property (state_r == dced_pkg::ST_IDLE && srv_pend_r
      |=> state_r == dced_pkg::ST_SERVO)
      else $error("servo event not served first");
   AST_PRIO_TIMER: assert property (state_r == dced_pkg::ST_IDLE && !srv_pend_r
      && !to_pend_r && tick_pend_r && io_pend_r |=> state_r == dced_pkg::ST_TICK)
      else $error("timer not served before request");
   AST_BACK_IDLE: assert property (state_r != dced_pkg::ST_IDLE |=> state_r == dced_pkg::ST_IDLE)
      else $error("handler did not return to idle");
   AST_FORWARD: assert property (state_r == dced_pkg::ST_IO && go_servo
      |=> srv_cmd_valid && busy_r && srv_cmd == $past(qcmd_r))
      else $error("servo command not forwarded");
   AST_TIMEOUT: assert property (to_hit && !srv_pend_r && !srv_evt |-> ##[1:4] srv_abort)
      else $error("overrun servo operation not aborted");
   AST_OUTCOME: assert property (state_r == dced_pkg::ST_SERVO && busy_r
      |=> ctl_done && ctl_ok == $past(sok_r))
      else $error("servo outcome not reported");
   AST_READY: assert property (srv_cmd_valid && (srv_cmd == dced_pkg::CMD_CYL_ZERO
      || srv_cmd == dced_pkg::CMD_OFFSET) |-> $past(ready_s))
      else $error("positioning command without ready");
   AST_SPEED: assert property (srv_cmd_valid && srv_cmd == dced_pkg::CMD_DIAG_EXEC
      |-> $past(speed_s))
      else $error("diagnostic without motor speed");
   AST_STATUS_ANY: assert property (state_r == dced_pkg::ST_IO
      && (qcmd_r == dced_pkg::CMD_OP_STAT || qcmd_r == dced_pkg::CMD_DIAG_STAT)
      |=> ctl_done && ctl_ok && !ctl_reject)
      else $error("status request refused");
   AST_PWR_BLOCK: assert property ($past(sbad_s) |=> !srv_cmd_valid)
      else $error("servo command under bad power");
   AST_PENDING: assert property (en_r && io_evt && state_r != dced_pkg::ST_IDLE |=> io_pend_r)
      else $error("request lost while busy");

   COV_SEEK_OK: cover property (srv_cmd_valid ##[1:200] (ctl_done && ctl_ok));
   COV_ABORT: cover property (srv_abort);
   COV_REJECT: cover property (ctl_reject);
   COV_WRAP: cover property (state_r == dced_pkg::ST_TICK && slice_r == 3'(SL_N - 1));

endmodule : dced_dispatcher
`default_nettype wire

//--- dced_pkg.sv
package dced_pkg;

   // clock and timer
   localparam int unsigned CLK_PERIOD_NS   = 40;
   localparam int unsigned TICK_PERIOD_NS  = 4_900_000;
   localparam int unsigned TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned SLICE_COUNT     = 6;

   // register bus
   localparam int unsigned ADDR_W          = 8;
   localparam int unsigned DATA_W          = 32;
   localparam logic [7:0]  REG_CTRL        = 8'h00;
   localparam logic [7:0]  REG_TIMEOUT     = 8'h04;
   localparam logic [7:0]  REG_STATUS      = 8'h08;
   localparam logic [7:0]  REG_RESULT      = 8'h0C;

   // control register fields
   localparam int unsigned CTRL_INIT_BIT   = 0;
   localparam logic [7:0]  TIMEOUT_RST     = 8'h0A;

   // controller request codes
   localparam int unsigned CMD_W           = 3;
   localparam logic [2:0]  CMD_CYL_ZERO    = 3'h0;
   localparam logic [2:0]  CMD_OFFSET      = 3'h1;
   localparam logic [2:0]  CMD_DIAG_EXEC   = 3'h2;
   localparam logic [2:0]  CMD_OP_STAT     = 3'h3;
   localparam logic [2:0]  CMD_DIAG_STAT   = 3'h4;
   localparam int unsigned OPND_W          = 8;

   // dispatcher states, gray along idle-tick-io-servo-abort
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_TICK  = 3'h1,
      ST_IO    = 3'h3,
      ST_SERVO = 3'h2,
      ST_ABORT = 3'h6
   } dced_state_t;

   // request needs the servo processor
   function automatic logic needs_servo(input logic [2:0] cmd);
      needs_servo = (cmd == CMD_CYL_ZERO) || (cmd == CMD_OFFSET) || (cmd == CMD_DIAG_EXEC);
   endfunction : needs_servo

   // precondition check for one request
   function automatic logic cmd_allowed(input logic [2:0] cmd,
                                        input logic       ready,
                                        input logic       at_speed,
                                        input logic       srv_block);
      case (cmd)
         CMD_CYL_ZERO, CMD_OFFSET: cmd_allowed = ready && !srv_block;
         CMD_DIAG_EXEC:       cmd_allowed = at_speed && !srv_block;
         CMD_OP_STAT, CMD_DIAG_STAT: cmd_allowed = 1'b1;
         default:             cmd_allowed = 1'b0;
      endcase
   endfunction : cmd_allowed

endpackage : dced_pkg

//--- dced_servo_model.sv
`timescale 1ns/1ns
`default_nettype none
// servo processor stand-in: one status report per accepted command
module dced_servo_model (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // command side
   input  wire logic       srv_cmd_valid,
   input  wire logic       srv_abort,
   // behaviour chosen by the bench
   input  wire logic       answer_en,
   input  wire logic       verdict,
   input  wire logic [7:0] delay,
   // status report pins
   output logic            srv_stat_strobe,
   output logic            srv_stat_ok
);
   logic [8:0] cnt_r;  // cycles left until the report is over

   // wait, set verdict, strobe four cycles, then let the verdict go stale
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 9'h000;
         srv_stat_strobe <= 1'b0;
         srv_stat_ok <= 1'b0;
      end else begin
         if (srv_cmd_valid && answer_en) begin
            cnt_r <= {1'b0, delay} + 9'h007;
         end else if (srv_abort) begin
            cnt_r <= 9'h000;  // aborted operation stays silent
         end else if (cnt_r != 9'h000) begin
            cnt_r <= cnt_r - 9'h001;
         end
         if (cnt_r == 9'h006) begin
            srv_stat_ok <= verdict;
         end else if (cnt_r == 9'h001) begin
            srv_stat_ok <= ~srv_stat_ok;  // inverted, line no longer valid
         end
         srv_stat_strobe <= (cnt_r >= 9'h002) && (cnt_r <= 9'h005);
      end
   end
endmodule : dced_servo_model
`default_nettype wire

//--- drive_control_event_dispatcher_test.sv
`timescale 1ns/1ns
`default_nettype none
module drive_control_event_dispatcher_test;
   localparam int TK = 50;  // shortened tick period
   // stimulus
   logic        sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00, ctl_operand = 8'h00, delay = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [2:0]  ctl_cmd = 3'h0;
   logic        ctl_req = 1'b0, unit_ready = 1'b0, motor_at_speed = 1'b0;
   logic        pwr_write_bad = 1'b0, pwr_servo_bad = 1'b0, answer_en = 1'b0, verdict = 1'b0;
   // observed
   logic [31:0] reg_rdata;
   logic        ctl_done, ctl_ok, ctl_reject, srv_cmd_valid, srv_abort;
   logic        srv_stat_strobe, srv_stat_ok, write_inhibit, servo_inhibit;
   logic [7:0]  ctl_data, srv_operand, got_data;
   logic [2:0]  srv_cmd;
   logic [5:0]  hk_slice_go, prev, cur;
   int          fails = 0, checks_done = 0, slice_cnt = 0, aborts = 0, t, a0;

   always #20 sys_clk = ~sys_clk;  // 25 MHz

   dced_dispatcher #(.TICK_CYCLES(TK)) i_dut (
      .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .ctl_req, .ctl_cmd, .ctl_operand, .ctl_done, .ctl_ok, .ctl_reject, .ctl_data,
      .srv_cmd_valid, .srv_cmd, .srv_operand, .srv_abort, .srv_stat_strobe, .srv_stat_ok,
      .unit_ready, .motor_at_speed, .pwr_write_bad, .pwr_servo_bad,
      .hk_slice_go, .write_inhibit, .servo_inhibit);

   dced_servo_model i_srv (
      .sys_clk, .rst_n, .srv_cmd_valid, .srv_abort, .answer_en, .verdict, .delay,
      .srv_stat_strobe, .srv_stat_ok);

   // pulse counters
   always @(posedge sys_clk) begin
      if (hk_slice_go != 6'h00) slice_cnt++;
      if (srv_abort === 1'b1) aborts++;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("FAIL at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run

   task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // read with mask; data stand only in the cycle after the strobe
   task automatic reg_read(input logic [7:0] addr, input logic [31:0] msk, exp);
      reg_addr <= addr;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      check(reg_rdata & msk, exp);
   endtask : reg_read

   // one controller request, answer sampled with ctl_done
   task automatic request(input logic [2:0] cmd, input logic [7:0] opnd,
                          input logic fwd, input logic ok, input logic rej);
      int   n;
      logic seen;
      n = 0;
      seen = 1'b0;
      ctl_cmd <= cmd;
      ctl_operand <= opnd;
      repeat (3) @(posedge sys_clk);
      ctl_req <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (srv_cmd_valid === 1'b1) begin
            seen = 1'b1;
            check({21'h0, srv_cmd, srv_operand}, {21'h0, cmd, opnd});
         end
      end while (ctl_done !== 1'b1 && n < 400);
      check({28'h0, ctl_done, seen, ctl_ok, ctl_reject}, {28'h0, 1'b1, fwd, ok, rej});
      got_data = ctl_data;
      ctl_req <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask : request

   task automatic next_slice(output logic [5:0] s);
      t = 0;
      do begin
         @(posedge sys_clk);
         t++;
      end while (hk_slice_go == 6'h00 && t < 1000);
      s = hk_slice_go;
   endtask : next_slice

   // watchdog, well beyond the expected run
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      complete_run();
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      check({30'h0, write_inhibit, servo_inhibit}, 32'h3);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check({30'h0, write_inhibit, servo_inhibit}, 32'h0);
      reg_read(dced_pkg::REG_TIMEOUT, 32'hFF, {24'h0, dced_pkg::TIMEOUT_RST});
      reg_read(8'h10, 32'hFFFFFFFF, 32'h0);
      repeat (3 * TK) @(posedge sys_clk);
      check(32'(slice_cnt), 32'h0);
      $display("test reset done");
      reg_write(dced_pkg::REG_CTRL, 32'h1);
      reg_read(dced_pkg::REG_CTRL, 32'h1, 32'h1);
      next_slice(prev);
      check({31'h0, $onehot(prev)}, 32'h1);
      for (int i = 0; i < 7; i++) begin
         next_slice(cur);
         check(32'(t), 32'(TK));
         check({26'h0, cur}, {26'h0, prev[4:0], prev[5]});
         prev = cur;
      end
      $display("test slices done");
      unit_ready <= 1'b1;
      request(dced_pkg::CMD_OP_STAT, 8'h00, 1'b0, 1'b1, 1'b0);
      check({24'h0, got_data}, 32'h01);
      pwr_write_bad <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check({31'h0, write_inhibit}, 32'h1);
      request(dced_pkg::CMD_OP_STAT, 8'h00, 1'b0, 1'b1, 1'b0);
      check({24'h0, got_data}, 32'h05);
      pwr_write_bad <= 1'b0;
      $display("test status done");
      unit_ready <= 1'b0;
      request(dced_pkg::CMD_CYL_ZERO, 8'h00, 1'b0, 1'b0, 1'b1);
      request(dced_pkg::CMD_OFFSET, 8'h11, 1'b0, 1'b0, 1'b1);
      request(3'h5, 8'h00, 1'b0, 1'b0, 1'b1);
      request(dced_pkg::CMD_DIAG_EXEC, 8'h00, 1'b0, 1'b0, 1'b1);
      unit_ready <= 1'b1;
      motor_at_speed <= 1'b1;
      pwr_servo_bad <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check({31'h0, servo_inhibit}, 32'h1);
      request(dced_pkg::CMD_CYL_ZERO, 8'h00, 1'b0, 1'b0, 1'b1);
      pwr_servo_bad <= 1'b0;
      repeat (4) @(posedge sys_clk);
      $display("test refusals done");
      answer_en <= 1'b1;
      verdict <= 1'b1;
      request(dced_pkg::CMD_CYL_ZERO, 8'h00, 1'b1, 1'b1, 1'b0);
      verdict <= 1'b0;
      delay <= 8'h78;
      request(dced_pkg::CMD_OFFSET, 8'h5A, 1'b1, 1'b0, 1'b0);
      verdict <= 1'b1;
      delay <= 8'h00;
      request(dced_pkg::CMD_DIAG_EXEC, 8'hA5, 1'b1, 1'b1, 1'b0);
      request(dced_pkg::CMD_DIAG_STAT, 8'h00, 1'b0, 1'b1, 1'b0);
      check({24'h0, got_data}, 32'h44);
      $display("test servo done");
      reg_write(dced_pkg::REG_TIMEOUT, 32'h2);
      answer_en <= 1'b0;
      a0 = aborts;
      request(dced_pkg::CMD_CYL_ZERO, 8'h3C, 1'b1, 1'b0, 1'b0);
      check(32'(aborts - a0), 32'h1);
      reg_read(dced_pkg::REG_RESULT, 32'h8000, 32'h8000);
      $display("test timeout done");
      complete_run();
   end
endmodule : drive_control_event_dispatcher_test
`default_nettype wire
